// ### hw/rdv_pkg.sv
/*
  Package for the clock date and alarm value registers: offsets, field positions, masks.
  Assumes a 32-bit AHB-Lite slave with word-aligned registers.
*/
package rdv_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CLOCK_CONTROL = 8'h00;
  localparam logic [7:0] OFS_CURRENT_DATE  = 8'h04;
  localparam logic [7:0] OFS_ALARM_TIME    = 8'h08;
  localparam logic [7:0] OFS_ALARM_DATE    = 8'h0c;
  localparam int         ADDR_BITS         = 8;

  // Clock control fields
  localparam int         CLOCK_WRITE_ENABLE_POS = 3;

  // Current date fields
  localparam int         YEAR_TENS_LSB   = 28;
  localparam int         YEAR_UNITS_LSB  = 24;
  localparam int         MONTH_TENS_POS  = 20;
  localparam int         MONTH_UNITS_LSB = 16;
  localparam int         DAY_TENS_LSB    = 12;
  localparam int         DAY_UNITS_LSB   = 8;
  localparam int         WEEKDAY_LSB     = 0;

  // Alarm time fields
  localparam int         HOUR_TENS_LSB   = 28;
  localparam int         HOUR_UNITS_LSB  = 24;
  localparam int         MIN_TENS_LSB    = 20;
  localparam int         MIN_UNITS_LSB   = 16;
  localparam int         SEC_TENS_LSB    = 12;
  localparam int         SEC_UNITS_LSB   = 8;

  // Implemented-bit masks, all other bits read as zero
  localparam logic [31:0] CONTROL_MASK    = 32'h0000_0008;
  localparam logic [31:0] DATE_MASK       = 32'hff1f_3f07;
  localparam logic [31:0] ALARM_TIME_MASK = 32'h3f7f_7f00;
  localparam logic [31:0] ALARM_DATE_MASK = 32'h001f_3f07;

  // Reset values
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [31:0] DATE_RESET    = 32'h0001_0100;
  localparam logic [31:0] ALARM_RESET   = 32'h0000_0000;
  localparam logic [31:0] ALARM_DATE_RESET = 32'h0001_0100;

  // Digit limits
  localparam logic [3:0] DIGIT_MAX      = 4'h9;
  localparam logic [3:0] MONTH_TENS_MAX = 4'h1;
  localparam logic [3:0] DAY_TENS_MAX   = 4'h3;
  localparam logic [3:0] HOUR_TENS_MAX  = 4'h2;
  localparam logic [3:0] SIX_TENS_MAX   = 4'h5;
  localparam logic [3:0] WEEKDAY_MAX    = 4'h6;

  // AHB-Lite codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;
endpackage : rdv_pkg

// ### hw/rdv_field_limit.sv
/*
  Per-register write filter: masks unused bits and clamps each BCD digit to its range.
  Assumes the caller selects which field table applies through sel.
*/
`timescale 1ns/1ps
module rdv_field_limit
(
  // Register kind: 0 date, 1 alarm time, 2 alarm date
  input  wire logic [1:0]  sel,
  // Raw and filtered word
  input  wire logic [31:0] raw,
  output logic      [31:0] clean
);

  function automatic logic [3:0] clamp(input logic [3:0] v, input logic [3:0] lim);
    clamp = (v > lim) ? lim : v;
  endfunction : clamp

  always_comb
  begin
    clean = 32'h0000_0000;
    unique case (sel)
      2'h0:
      begin
        clean[31:28] = clamp(raw[31:28], rdv_pkg::DIGIT_MAX);  // RULE1
        clean[27:24] = clamp(raw[27:24], rdv_pkg::DIGIT_MAX);  // RULE1
        clean[20]    = raw[20];  // RULE2
        clean[19:16] = clamp(raw[19:16], rdv_pkg::DIGIT_MAX);  // RULE2
        clean[13:12] = raw[13:12];  // RULE3
        clean[11:8]  = clamp(raw[11:8], rdv_pkg::DIGIT_MAX);  // RULE3
        clean[2:0]   = 3'(clamp({1'b0, raw[2:0]}, rdv_pkg::WEEKDAY_MAX));  // RULE4
      end
      2'h1:
      begin
        clean[29:28] = 2'(clamp({2'h0, raw[29:28]}, rdv_pkg::HOUR_TENS_MAX));  // RULE6
        clean[27:24] = clamp(raw[27:24], rdv_pkg::DIGIT_MAX);  // RULE6
        clean[22:20] = 3'(clamp({1'b0, raw[22:20]}, rdv_pkg::SIX_TENS_MAX));  // RULE7
        clean[19:16] = clamp(raw[19:16], rdv_pkg::DIGIT_MAX);  // RULE7
        clean[14:12] = 3'(clamp({1'b0, raw[14:12]}, rdv_pkg::SIX_TENS_MAX));  // RULE8
        clean[11:8]  = clamp(raw[11:8], rdv_pkg::DIGIT_MAX);  // RULE8
      end
      2'h2:
      begin
        clean[20]    = raw[20];  // RULE10
        clean[19:16] = clamp(raw[19:16], rdv_pkg::DIGIT_MAX);  // RULE10
        clean[13:12] = raw[13:12];  // RULE11
        clean[11:8]  = clamp(raw[11:8], rdv_pkg::DIGIT_MAX);  // RULE11
        clean[2:0]   = 3'(clamp({1'b0, raw[2:0]}, rdv_pkg::WEEKDAY_MAX));  // RULE12
      end
      default:
      begin
        clean = raw & rdv_pkg::CONTROL_MASK;
      end
    endcase
  end

endmodule : rdv_field_limit

// ### hw/rdv_regs.sv
/*
  Date, alarm time and alarm date value registers with a clock control register, AHB-Lite slave.
  Assumes a single AHB-Lite master, word transfers, synchronous active-high reset and ce as clock enable.
*/
`timescale 1ns/1ps
// Summary of operation
// RULE1: Year tens 31-28, units 27-24, BCD.
// RULE2: Month tens bit 20, units 19-16.
// RULE3: Day tens 13-12, units 11-8.
// RULE4: Weekday bits 2-0, 0-6; gaps read zero.
// RULE5: Date writable only with write enable set.
// RULE6: Alarm hour tens 29-28, units 27-24.
// RULE7: Alarm minute tens 22-20, units 19-16.
// RULE8: Alarm second tens 14-12, units 11-8.
// RULE9: Alarm time unused bits read zero.
// RULE10: Alarm month tens bit 20, units 19-16.
// RULE11: Alarm day tens 13-12, units 11-8.
// RULE12: Alarm weekday bits 2-0, 0-6.
// RULE13: Alarm date unused bits read zero.
// RULE14: Disabled date write leaves date unchanged.
module rdv_regs
(
  // Clock, reset, enable
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        ce,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Register contents for the counting and alarm logic
  output logic      [31:0] date_out,
  output logic      [31:0] alarm_time_out,
  output logic      [31:0] alarm_date_out,
  output logic             clock_write_enable
);

  logic [31:0] control_reg;
  logic [31:0] date_reg;
  logic [31:0] alarm_time_reg;
  logic [31:0] alarm_date_reg;
  logic [31:0] rdata_next;
  logic        wr_pend_reg;
  logic [rdv_pkg::ADDR_BITS-1:0] wr_addr_reg;
  logic [1:0]  filt_sel;
  logic [31:0] filt_word;
  logic        take;
  logic [rdv_pkg::ADDR_BITS-1:0] rd_addr;

  // Address phase accepted on any valid word transfer
  assign take    = hsel && hready && (htrans == rdv_pkg::HTRANS_NONSEQ || htrans == rdv_pkg::HTRANS_SEQ);
  assign rd_addr = haddr[rdv_pkg::ADDR_BITS-1:0];

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
    end
    else if (ce)
    begin
      wr_pend_reg <= take && hwrite;
      wr_addr_reg <= rd_addr;
    end
  end

  always_comb
  begin
    unique case (wr_addr_reg)
      rdv_pkg::OFS_CURRENT_DATE: filt_sel = 2'h0;
      rdv_pkg::OFS_ALARM_TIME:   filt_sel = 2'h1;
      rdv_pkg::OFS_ALARM_DATE:   filt_sel = 2'h2;
      default:                   filt_sel = 2'h3;
    endcase
  end

  rdv_field_limit u_limit
  (
    .sel   (filt_sel),
    .raw   (hwdata),
    .clean (filt_word)
  );

  // Write data lands in the data phase, one cycle after the address
  always_ff @(posedge mclk)
  begin
    if (reset)
      control_reg <= rdv_pkg::CONTROL_RESET;
    else if (ce && wr_pend_reg && wr_addr_reg == rdv_pkg::OFS_CLOCK_CONTROL)
      control_reg <= filt_word;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      date_reg <= rdv_pkg::DATE_RESET;
    else if (ce && wr_pend_reg && wr_addr_reg == rdv_pkg::OFS_CURRENT_DATE
             && control_reg[rdv_pkg::CLOCK_WRITE_ENABLE_POS])  // RULE5
      date_reg <= filt_word & rdv_pkg::DATE_MASK;  // RULE4
    // Otherwise the date holds its value
  end  // RULE14

  always_ff @(posedge mclk)
  begin
    if (reset)
      alarm_time_reg <= rdv_pkg::ALARM_RESET;
    else if (ce && wr_pend_reg && wr_addr_reg == rdv_pkg::OFS_ALARM_TIME)
      alarm_time_reg <= filt_word & rdv_pkg::ALARM_TIME_MASK;  // RULE9
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      alarm_date_reg <= rdv_pkg::ALARM_DATE_RESET;
    else if (ce && wr_pend_reg && wr_addr_reg == rdv_pkg::OFS_ALARM_DATE)
      alarm_date_reg <= filt_word & rdv_pkg::ALARM_DATE_MASK;  // RULE13
  end

  // Read data registered at the address phase; a write in flight to the same word is visible next access
  always_comb
  begin
    unique case (rd_addr)
      rdv_pkg::OFS_CLOCK_CONTROL: rdata_next = control_reg & rdv_pkg::CONTROL_MASK;
      rdv_pkg::OFS_CURRENT_DATE:  rdata_next = date_reg & rdv_pkg::DATE_MASK;  // RULE4
      rdv_pkg::OFS_ALARM_TIME:    rdata_next = alarm_time_reg & rdv_pkg::ALARM_TIME_MASK;  // RULE9
      rdv_pkg::OFS_ALARM_DATE:    rdata_next = alarm_date_reg & rdv_pkg::ALARM_DATE_MASK;  // RULE13
      default:                    rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      hrdata <= 32'h0000_0000;
    else if (ce && take && !hwrite)
      hrdata <= rdata_next;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else if (ce)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      date_out           <= rdv_pkg::DATE_RESET;
      alarm_time_out     <= rdv_pkg::ALARM_RESET;
      alarm_date_out     <= rdv_pkg::ALARM_DATE_RESET;
      clock_write_enable <= 1'b0;
    end
    else if (ce)
    begin
      date_out           <= date_reg;
      alarm_time_out     <= alarm_time_reg;
      alarm_date_out     <= alarm_date_reg;
      clock_write_enable <= control_reg[rdv_pkg::CLOCK_WRITE_ENABLE_POS];
    end
  end

endmodule : rdv_regs

// ### test/rdv_monitor.sv
/*
  Checker on rdv_regs ports: field ranges, zero bits, write lock, read-back.
  Assumes one clock and a synchronous reset; bound at the foot.
*/
`timescale 1ns/1ps
module rdv_monitor
(
  // Clock, reset, enable
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        ce,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  // Register copies
  input wire logic [31:0] date_out,
  input wire logic [31:0] alarm_time_out,
  input wire logic [31:0] alarm_date_out,
  input wire logic        clock_write_enable
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  sequence rd_s(logic [7:0] ofs);
    ce && hsel && hready && htrans[1] && !hwrite && haddr[7:0] == ofs;
  endsequence
  // Copies lag the register, so wait two enabled edges
  sequence settle_s;
    ce [*2];
  endsequence
  resp_okay_a:
    assert property (!hresp) else $error("error response seen");
  date_rsvd_a:
    assert property (!(date_out & 32'h00e0_c0f8)) else $error("date zero bits set");
  atime_rsvd_a:
    assert property (!(alarm_time_out & 32'hc080_80ff)) else $error("alarm time zero bits set");
  adate_rsvd_a:
    assert property (!(alarm_date_out & 32'hffe0_c0f8)) else $error("alarm date zero bits set");
  date_bcd_a:
    assert property (date_out[31:28] < 4'ha && date_out[27:24] < 4'ha && date_out[19:16] < 4'ha
      && date_out[11:8] < 4'ha && date_out[2:0] < 3'h7) else $error("date digit out of range");
  atime_bcd_a:
    assert property (alarm_time_out[29:28] < 2'h3 && alarm_time_out[27:24] < 4'ha && alarm_time_out[22:20] < 3'h6
      && alarm_time_out[19:16] < 4'ha && alarm_time_out[14:12] < 3'h6 && alarm_time_out[11:8] < 4'ha)
      else $error("alarm time digit out of range");
  adate_bcd_a:
    assert property (alarm_date_out[19:16] < 4'ha && alarm_date_out[11:8] < 4'ha && alarm_date_out[2:0] < 3'h7)
      else $error("alarm date digit out of range");
  date_lock_a:
    assert property ($changed(date_out) |-> $past(clock_write_enable)) else $error("date changed while locked");
  atime_rd_a:
    assert property (rd_s(rdv_pkg::OFS_ALARM_TIME) ##1 settle_s |-> alarm_time_out == $past(hrdata))
      else $error("alarm time read differs from copy");
  date_rd_a:
    assert property (rd_s(rdv_pkg::OFS_CURRENT_DATE) ##1 settle_s |-> date_out == $past(hrdata))
      else $error("date read differs from copy");
endmodule : rdv_monitor

bind rdv_regs rdv_monitor MON (.mclk, .reset, .ce, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .hresp,
  .date_out, .alarm_time_out, .alarm_date_out, .clock_write_enable);

// ### test/rdv_regs_tb.sv
/*
  Self-checking bench for rdv_regs over AHB-Lite.
  Assumes zero wait states, hready looped from hreadyout, one slave.
*/
`timescale 1ns/1ps
module rdv_regs_tb;
  logic        mclk   = 1'b0;
  logic        reset  = 1'b1;
  logic        ce     = 1'b1;
  logic [31:0] haddr  = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, date_out, alarm_time_out, alarm_date_out, rd;
  logic        hreadyout, hresp, clock_write_enable;
  int          fails      = 0;
  int          num_checks = 0;
  int          cycles     = 0;

  always #12.5 mclk = ~mclk;

  rdv_regs DUT (.mclk, .reset, .ce, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(rdv_pkg::HSIZE_WORD),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .date_out, .alarm_time_out, .alarm_date_out,
    .clock_write_enable);

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude

  // Single word transfer; read data lands in rd
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= rdv_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic t_reset();
    logic [31:0] exp [5] = '{rdv_pkg::CONTROL_RESET, rdv_pkg::DATE_RESET, rdv_pkg::ALARM_RESET,
                             rdv_pkg::ALARM_DATE_RESET, 32'h0};
    for (int i = 0; i < 5; i++)
    begin
      bus(1'b0, 8'(4 * i), 32'h0);
      check("reset read", rd, exp[i]);
    end
    $display("test reset done");
  endtask : t_reset

  task automatic t_lock();
    bus(1'b1, rdv_pkg::OFS_CURRENT_DATE, 32'h2412_3105);
    bus(1'b0, rdv_pkg::OFS_CURRENT_DATE, 32'h0);
    check("locked date", rd, rdv_pkg::DATE_RESET);
    bus(1'b1, rdv_pkg::OFS_CLOCK_CONTROL, 32'hffff_ffff);
    bus(1'b0, rdv_pkg::OFS_CLOCK_CONTROL, 32'h0);
    check("control", rd, 32'h0000_0008);
    bus(1'b1, rdv_pkg::OFS_CURRENT_DATE, 32'h2412_3105);
    check("enable copy", {31'h0, clock_write_enable}, 32'h1);
    bus(1'b0, rdv_pkg::OFS_CURRENT_DATE, 32'h0);
    check("open date", rd, 32'h2412_3105);
    bus(1'b1, rdv_pkg::OFS_CLOCK_CONTROL, 32'h0);
    bus(1'b1, rdv_pkg::OFS_CURRENT_DATE, 32'h1101_0203);
    bus(1'b0, rdv_pkg::OFS_CURRENT_DATE, 32'h0);
    check("relocked date", rd, 32'h2412_3105);
    bus(1'b1, rdv_pkg::OFS_CLOCK_CONTROL, 32'h0000_0008);
    $display("test lock done");
  endtask : t_lock

  // Legal maxima first, then all ones to hit zero bits and clamps; 0x10 is unmapped
  task automatic t_fields();
    logic [7:0]  ofs [7] = '{8'h04, 8'h08, 8'h0c, 8'h04, 8'h08, 8'h0c, 8'h10};
    logic [31:0] wr  [7] = '{32'h9912_3106, 32'h2359_5900, 32'h0012_3106, '1, '1, '1, '1};
    logic [31:0] ex  [7] = '{32'h9912_3106, 32'h2359_5900, 32'h0012_3106, 32'h9919_3906, 32'h2959_5900,
                             32'h0019_3906, 32'h0};
    for (int i = 0; i < 7; i++)
    begin
      bus(1'b1, ofs[i], wr[i]);
      bus(1'b0, ofs[i], 32'h0);
      check("field read", rd, ex[i]);
    end
    check("date copy", date_out, 32'h9919_3906);
    check("alarm time copy", alarm_time_out, 32'h2959_5900);
    check("alarm date copy", alarm_date_out, 32'h0019_3906);
    $display("test fields done");
  endtask : t_fields

  task automatic t_ce();
    ce <= 1'b0;
    bus(1'b1, rdv_pkg::OFS_ALARM_TIME, 32'h1200_0000);
    ce <= 1'b1;
    bus(1'b0, rdv_pkg::OFS_ALARM_TIME, 32'h0);
    check("frozen alarm", rd, 32'h2959_5900);
    reset <= 1'b1;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    $display("test hold done");
  endtask : t_ce

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      fails++;
      conclude();
    end
  end

  initial
  begin
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    t_reset();
    t_lock();
    t_fields();
    t_ce();
    t_reset();
    conclude();
  end
endmodule : rdv_regs_tb
